// >>> core/dcp_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_buffer
  import dcp_pkg::*;
#(
  parameter int WIDTH = DCP_DATA_W,
  parameter int DEPTH = DCP_BUF_DEPTH
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      fill_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (fill_reg != (AW+1)'(DEPTH));
  assign out_valid = (fill_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg   <= '0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= wrap_inc(wr_ptr_reg);
      end
      if (pop)
        rd_ptr_reg <= wrap_inc(rd_ptr_reg);
      if (push && !pop)
        fill_reg <= fill_reg + (AW+1)'(1);
      else if (pop && !push)
        fill_reg <= fill_reg - (AW+1)'(1);
    end
  end

endmodule // dcp_buffer
`default_nettype wire

// >>> core/dcp_channel.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Pointers are 20 bits from low/high registers
// - Upper pointer bits always driven, even I/O
// - Fetch drives source pointer on address
// - Deposit drives destination pointer on address
// - Separate memory/I-O select per pointer
// - Increment-only up, decrement-only down, equal holds
// - Step follows programmed transfer width
// - Word steps two, byte steps one
// - Stop-at-zero bit halts at zero count
// - Synchronized runs on; unsynchronized stops at zero
// - Terminal count clears arm; software may too
// - Count request needs interrupt and stop bits
// - Sync field: none, source, destination; not 11
// - Priority bit sets high or low priority
// - Equal priorities rotate between the two channels
// - Request source: timer 2 or external pin
// - Writes change arm only with change-enable set
// - Width bit selects word or byte transfers
module dcp_channel
  import dcp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        pcb_wr_en,
  input  wire logic        pcb_rd_en,
  input  wire logic [2:0]  pcb_index,
  input  wire logic [15:0] pcb_wdata,
  output logic      [15:0] pcb_rdata,
  input  wire logic        external_request_pin,
  input  wire logic        timer2_request,
  input  wire logic        channel_is_one,
  input  wire logic        peer_request,
  input  wire logic        peer_priority_high,
  input  wire logic        peer_transfer_done,
  input  wire logic        peer_bus_released,
  output logic             channel_request,
  output logic             priority_high,
  output logic             transfer_done,
  output logic             bus_released,
  output logic             bus_req,
  output logic             bus_write,
  output logic             bus_mem_space,
  output logic             bus_word,
  output logic      [19:0] bus_addr,
  output logic      [15:0] bus_wdata,
  input  wire logic        bus_ack,
  input  wire logic [15:0] bus_rdata,
  output logic             tc_irq_request,
  output logic             channel_armed
);

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  logic        dest_space_select_reg;
  logic        dest_decrement_reg;
  logic        dest_increment_reg;
  logic        source_space_select_reg;
  logic        source_decrement_reg;
  logic        source_increment_reg;
  logic        stop_at_zero_count_reg;
  logic        tc_int_enable_reg;
  dcp_sync_t   sync_select_reg;
  logic        prio_reg;
  logic        request_source_select_reg;
  logic        channel_arm_reg;
  logic        word_reg;
  logic [15:0] count_reg;
  logic        timer_pending_reg;
  logic        turn_reg;
  dcp_state_t  state_reg;
  dcp_state_t  state_next;
  logic [1:0]  idle_cnt_reg;

  // Registered outputs
  logic        chan_req_reg;
  logic        done_reg;
  logic        released_reg;
  logic        bus_req_reg;
  logic        bus_write_reg;
  logic        bus_mem_reg;
  logic [19:0] bus_addr_reg;
  logic [15:0] bus_wdata_reg;
  logic        irq_reg;
  logic [15:0] rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_src_lo = pcb_wr_en && (pcb_index == DCP_IDX_SRC_LO);
  wire wr_src_hi = pcb_wr_en && (pcb_index == DCP_IDX_SRC_HI);
  wire wr_dst_lo = pcb_wr_en && (pcb_index == DCP_IDX_DST_LO);
  wire wr_dst_hi = pcb_wr_en && (pcb_index == DCP_IDX_DST_HI);
  wire wr_count  = pcb_wr_en && (pcb_index == DCP_IDX_COUNT);
  wire wr_ctrl   = pcb_wr_en && (pcb_index == DCP_IDX_CTRL);
  wire arm_write = wr_ctrl && pcb_wdata[DCP_B_CEN];

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and data buffer
  logic [19:0] src_ptr;
  logic [19:0] dst_ptr;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [15:0] buf_out_data;

  wire deposit_ack = state_reg[2] && bus_req_reg && bus_ack;
  wire fetch_ack   = state_reg[1] && bus_req_reg && bus_ack;

  dcp_pointer u_src_ptr (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .load_lo   (wr_src_lo),
    .load_hi   (wr_src_hi),
    .wdata     (pcb_wdata),
    .step_en   (deposit_ack),
    .increment (source_increment_reg),
    .decrement (source_decrement_reg),
    .word      (word_reg),
    .ptr       (src_ptr)
  );

  dcp_pointer u_dst_ptr (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .load_lo   (wr_dst_lo),
    .load_hi   (wr_dst_hi),
    .wdata     (pcb_wdata),
    .step_en   (deposit_ack),
    .increment (dest_increment_reg),
    .decrement (dest_decrement_reg),
    .word      (word_reg),
    .ptr       (dst_ptr)
  );

  // Fetched word waits here until the deposit cycle is accepted
  dcp_buffer #(
    .WIDTH (DCP_DATA_W),
    .DEPTH (DCP_BUF_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (fetch_ack),
    .in_ready  (buf_in_ready),
    .in_data   (bus_rdata),
    .out_valid (buf_out_valid),
    .out_ready (deposit_ack),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request selection and arbitration
  wire unsync      = (sync_select_reg == DCP_SYNC_NONE);
  wire sel_request = request_source_select_reg ? timer_pending_reg
                                               : external_request_pin;
  wire count_live  = (count_reg != '0);
  // Unsynchronized channels run freely until the count is spent
  wire want        = channel_arm_reg && buf_in_ready
                     && (unsync ? count_live : sel_request);
  wire same_prio   = (prio_reg == peer_priority_high);
  wire win         = !peer_request
                     || (prio_reg && !peer_priority_high)
                     || (same_prio && turn_reg);
  wire start       = state_reg[0] && want && win;

  wire [15:0] count_dec   = count_reg - DCP_COUNT_ONE;
  wire        hit_zero    = deposit_ack && (count_dec == '0);
  wire        terminate   = hit_zero && (stop_at_zero_count_reg || unsync);
  wire        dst_sync    = (sync_select_reg == DCP_SYNC_DST);
  wire        idle_done   = (idle_cnt_reg == DCP_DST_IDLE_CYC - 2'h1);
  wire        quiet       = !want && !peer_request;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DCP_ST_IDLE:
        if (start)
          state_next = DCP_ST_FETCH;
      DCP_ST_FETCH:
        if (fetch_ack)
          state_next = DCP_ST_DEPOSIT;
      DCP_ST_DEPOSIT:
        if (deposit_ack)
          state_next = dst_sync ? DCP_ST_RELEASE : DCP_ST_IDLE;
      DCP_ST_RELEASE:
        if (idle_done)
          state_next = DCP_ST_IDLE;
      default:
        state_next = DCP_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= DCP_ST_IDLE;
      idle_cnt_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      state_reg    <= state_next;
      idle_cnt_reg <= state_reg[3] ? idle_cnt_reg + 2'h1 : 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and count
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dest_space_select_reg     <= 1'b0;
      dest_decrement_reg        <= 1'b0;
      dest_increment_reg        <= 1'b0;
      source_space_select_reg   <= 1'b0;
      source_decrement_reg      <= 1'b0;
      source_increment_reg      <= 1'b0;
      stop_at_zero_count_reg    <= 1'b0;
      tc_int_enable_reg         <= 1'b0;
      sync_select_reg           <= DCP_SYNC_NONE;
      prio_reg                  <= 1'b0;
      request_source_select_reg <= 1'b0;
      word_reg                  <= 1'b0;
    end
    else if (clk_en && wr_ctrl)
    begin
      dest_space_select_reg     <= pcb_wdata[DCP_B_DST_MEM];
      dest_decrement_reg        <= pcb_wdata[DCP_B_DST_DEC];
      dest_increment_reg        <= pcb_wdata[DCP_B_DST_INC];
      source_space_select_reg   <= pcb_wdata[DCP_B_SRC_MEM];
      source_decrement_reg      <= pcb_wdata[DCP_B_SRC_DEC];
      source_increment_reg      <= pcb_wdata[DCP_B_SRC_INC];
      stop_at_zero_count_reg    <= pcb_wdata[DCP_B_STOP_TC];
      tc_int_enable_reg         <= pcb_wdata[DCP_B_TC_INT];
      sync_select_reg           <= dcp_sync_t'(pcb_wdata[DCP_B_SYNC_HI:DCP_B_SYNC_LO]);
      prio_reg                  <= pcb_wdata[DCP_B_PRIO];
      request_source_select_reg <= pcb_wdata[DCP_B_REQ_SRC];
      word_reg                  <= pcb_wdata[DCP_B_WORD];
    end
  end

  // A software arm in the same cycle as terminal count wins
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      channel_arm_reg <= 1'b0;
    else if (clk_en)
    begin
      if (arm_write)
        channel_arm_reg <= pcb_wdata[DCP_B_ARM];
      else if (terminate)
        channel_arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      count_reg <= DCP_REG_RST;
    else if (clk_en)
    begin
      if (wr_count)
        count_reg <= pcb_wdata;
      else if (deposit_ack)
        count_reg <= count_dec;
    end
  end

  // Timer pulse held until a transfer consumes it; a new pulse wins
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      timer_pending_reg <= 1'b0;
    else if (clk_en)
    begin
      if (timer2_request)
        timer_pending_reg <= 1'b1;
      else if (start && request_source_select_reg)
        timer_pending_reg <= 1'b0;
    end
  end

  // Rotation: channel one leads whenever the bus is let go
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      turn_reg <= 1'b0;
    else if (clk_en)
    begin
      if (released_reg || peer_bus_released || (quiet && state_reg[0]))
        turn_reg <= channel_is_one;
      else if (done_reg)
        turn_reg <= 1'b0;
      else if (peer_transfer_done)
        turn_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle drive
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bus_req_reg   <= 1'b0;
      bus_write_reg <= 1'b0;
      bus_mem_reg   <= 1'b0;
      bus_addr_reg  <= DCP_PTR_RST;
      bus_wdata_reg <= DCP_REG_RST;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        bus_req_reg   <= 1'b1;
        bus_write_reg <= 1'b0;
        bus_mem_reg   <= source_space_select_reg;
        bus_addr_reg  <= src_ptr;
      end
      else if (fetch_ack)
        bus_req_reg <= 1'b0;
      else if (state_reg[2] && !bus_req_reg && buf_out_valid)
      begin
        bus_req_reg   <= 1'b1;
        bus_write_reg <= 1'b1;
        bus_mem_reg   <= dest_space_select_reg;
        bus_addr_reg  <= dst_ptr;
        bus_wdata_reg <= buf_out_data;
      end
      else if (deposit_ack)
        bus_req_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and events
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      chan_req_reg <= 1'b0;
      done_reg     <= 1'b0;
      released_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end
    else if (clk_en)
    begin
      chan_req_reg <= want;
      done_reg     <= deposit_ack;
      released_reg <= state_reg[3] && idle_done;
      irq_reg      <= hit_zero && stop_at_zero_count_reg && tc_int_enable_reg;
    end
  end

  // Change-enable reads back as zero; it only qualifies a write
  wire [15:0] ctrl_view = {dest_space_select_reg, dest_decrement_reg, dest_increment_reg,
                           source_space_select_reg, source_decrement_reg,
                           source_increment_reg, stop_at_zero_count_reg,
                           tc_int_enable_reg, sync_select_reg, prio_reg,
                           request_source_select_reg, 2'b00, channel_arm_reg, word_reg};
  wire [15:0] read_mux  = (pcb_index == DCP_IDX_SRC_LO) ? src_ptr[15:0] :
                          (pcb_index == DCP_IDX_SRC_HI) ? {12'h000, src_ptr[19:16]} :
                          (pcb_index == DCP_IDX_DST_LO) ? dst_ptr[15:0] :
                          (pcb_index == DCP_IDX_DST_HI) ? {12'h000, dst_ptr[19:16]} :
                          (pcb_index == DCP_IDX_COUNT)  ? count_reg :
                          (pcb_index == DCP_IDX_CTRL)   ? ctrl_view : 16'h0000;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rdata_reg <= DCP_REG_RST;
    else if (clk_en && pcb_rd_en)
      rdata_reg <= read_mux;
  end

  reg prio_out_reg;
  reg armed_out_reg;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      prio_out_reg  <= 1'b0;
      armed_out_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      prio_out_reg  <= prio_reg;
      armed_out_reg <= channel_arm_reg;
    end
  end

  reg word_out_reg;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      word_out_reg <= 1'b0;
    else if (clk_en && start)
      word_out_reg <= word_reg;
  end

  assign pcb_rdata       = rdata_reg;
  assign channel_request = chan_req_reg;
  assign priority_high   = prio_out_reg;
  assign transfer_done   = done_reg;
  assign bus_released    = released_reg;
  assign bus_req         = bus_req_reg;
  assign bus_write       = bus_write_reg;
  assign bus_mem_space   = bus_mem_reg;
  assign bus_word        = word_out_reg;
  assign bus_addr        = bus_addr_reg;
  assign bus_wdata       = bus_wdata_reg;
  assign tc_irq_request  = irq_reg;
  assign channel_armed   = armed_out_reg;

endmodule // dcp_channel
`default_nettype wire

// >>> core/dcp_pkg.sv
package dcp_pkg;

  // Register indices within one channel's block of the peripheral control block
  localparam logic [2:0] DCP_IDX_SRC_LO  = 3'h0;
  localparam logic [2:0] DCP_IDX_SRC_HI  = 3'h1;
  localparam logic [2:0] DCP_IDX_DST_LO  = 3'h2;
  localparam logic [2:0] DCP_IDX_DST_HI  = 3'h3;
  localparam logic [2:0] DCP_IDX_COUNT   = 3'h4;
  localparam logic [2:0] DCP_IDX_CTRL    = 3'h5;

  // channel_control field positions
  localparam int DCP_B_DST_MEM   = 15;
  localparam int DCP_B_DST_DEC   = 14;
  localparam int DCP_B_DST_INC   = 13;
  localparam int DCP_B_SRC_MEM   = 12;
  localparam int DCP_B_SRC_DEC   = 11;
  localparam int DCP_B_SRC_INC   = 10;
  localparam int DCP_B_STOP_TC   = 9;
  localparam int DCP_B_TC_INT    = 8;
  localparam int DCP_B_SYNC_HI   = 7;
  localparam int DCP_B_SYNC_LO   = 6;
  localparam int DCP_B_PRIO      = 5;
  localparam int DCP_B_REQ_SRC   = 4;
  localparam int DCP_B_CEN       = 2;
  localparam int DCP_B_ARM       = 1;
  localparam int DCP_B_WORD      = 0;

  // Widths and reset values
  localparam int          DCP_LO_W        = 16;
  localparam int          DCP_HI_W        = 4;
  localparam int          DCP_PTR_W       = 20;
  localparam int          DCP_DATA_W      = 16;
  localparam int          DCP_BUF_DEPTH   = 2;
  localparam logic [19:0] DCP_PTR_RST     = 20'h00000;
  localparam logic [15:0] DCP_REG_RST     = 16'h0000;
  localparam logic [15:0] DCP_COUNT_ONE   = 16'h0001;

  // Idle cycles after a destination synchronized deposit
  localparam logic [1:0]  DCP_DST_IDLE_CYC = 2'h2;

  typedef enum logic [1:0] {
    DCP_SYNC_NONE = 2'b00,
    DCP_SYNC_SRC  = 2'b01,
    DCP_SYNC_DST  = 2'b10,
    DCP_SYNC_RSVD = 2'b11
  } dcp_sync_t;

  typedef enum logic [3:0] {
    DCP_ST_IDLE    = 4'b0001,
    DCP_ST_FETCH   = 4'b0010,
    DCP_ST_DEPOSIT = 4'b0100,
    DCP_ST_RELEASE = 4'b1000
  } dcp_state_t;

  // Pointer step follows the transfer width: two for words, one for bytes
  function automatic logic [19:0] dcp_step(input logic word);
    dcp_step = word ? 20'h00002 : 20'h00001;
  endfunction

endpackage

// >>> core/dcp_pointer.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_pointer
  import dcp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        load_lo,
  input  wire logic        load_hi,
  input  wire logic [15:0] wdata,
  input  wire logic        step_en,
  input  wire logic        increment,
  input  wire logic        decrement,
  input  wire logic        word,
  output logic      [19:0] ptr
);

  logic [19:0] ptr_reg;
  logic [19:0] ptr_next;
  logic [19:0] step;

  assign step = dcp_step(word);

  // Equal increment and decrement bits hold the pointer
  assign ptr_next = (step_en && increment && !decrement) ? ptr_reg + step :
                    (step_en && decrement && !increment) ? ptr_reg - step :
                    ptr_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ptr_reg <= DCP_PTR_RST;
    else if (clk_en)
    begin
      if (load_lo)
        ptr_reg[15:0] <= wdata;
      else if (load_hi)
        ptr_reg[19:16] <= wdata[3:0];
      else
        ptr_reg <= ptr_next;
    end
  end

  assign ptr = ptr_reg;

endmodule // dcp_pointer
`default_nettype wire

// >>> verification/dcp_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_bus_model
  import dcp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        bus_req,
  input  wire logic [19:0] bus_addr,
  output logic             bus_ack,
  output logic      [15:0] bus_rdata
);
  logic [1:0] wait_reg;

  // Idle data toggles so a stale word is never mistaken for a fetch
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bus_ack   <= 1'b0;
      wait_reg  <= 2'h0;
      bus_rdata <= 16'h0000;
    end
    else if (bus_ack)
    begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end
    else if (bus_req && (!slow || wait_reg == 2'h3))
    begin
      bus_ack   <= 1'b1;
      wait_reg  <= 2'h0;
      bus_rdata <= bus_addr[15:0] ^ 16'h5A5A;
    end
    else
    begin
      wait_reg  <= bus_req ? wait_reg + 2'h1 : 2'h0;
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule // dcp_bus_model
`default_nettype wire

// >>> verification/dcp_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_checker
  import dcp_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        pcb_rd_en,
  input wire logic [15:0] pcb_rdata,
  input wire logic        transfer_done,
  input wire logic        bus_released,
  input wire logic        bus_req,
  input wire logic        bus_write,
  input wire logic        bus_mem_space,
  input wire logic [19:0] bus_addr,
  input wire logic        bus_ack,
  input wire logic        tc_irq_request,
  input wire logic        channel_armed
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |=>
    !bus_req && !transfer_done && !channel_armed && !tc_irq_request)
    else $error("outputs active after reset");
  AST_REQ_HOLD: assert property (bus_req && !bus_ack |=> bus_req
    && $stable(bus_addr) && $stable(bus_write) && $stable(bus_mem_space))
    else $error("bus request changed before ack");
  AST_ACK_DROPS: assert property (bus_req && bus_ack |=> !bus_req)
    else $error("bus request held after ack");
  AST_FETCH_DEP: assert property (bus_req && bus_ack && !bus_write |=>
    !bus_req ##1 (bus_req && bus_write))
    else $error("deposit did not follow fetch");
  AST_DONE: assert property (bus_req && bus_ack && bus_write |=> transfer_done)
    else $error("no done after deposit");
  AST_DONE_PULSE: assert property (transfer_done |=> !transfer_done)
    else $error("done longer than one cycle");
  AST_IRQ: assert property (tc_irq_request |-> transfer_done)
    else $error("count request without transfer");
  AST_RDATA_HOLD: assert property (!pcb_rd_en && !$past(pcb_rd_en) |=>
    $stable(pcb_rdata))
    else $error("read data changed without read");

  // Main scenarios reached
  cover property (bus_req && bus_ack && bus_write);
  cover property (tc_irq_request);
  cover property (bus_released);
endmodule // dcp_checker

bind dcp_channel dcp_checker dcp_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .pcb_rd_en(pcb_rd_en), .pcb_rdata(pcb_rdata), .transfer_done(transfer_done),
  .bus_released(bus_released), .bus_req(bus_req), .bus_write(bus_write),
  .bus_mem_space(bus_mem_space), .bus_addr(bus_addr), .bus_ack(bus_ack),
  .tc_irq_request(tc_irq_request), .channel_armed(channel_armed));
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dcp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [2:0]  idx = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        ext_pin = 1'b0;
  logic        tmr = 1'b0;
  logic        p_req = 1'b0;
  logic        p_hi = 1'b0;
  logic        p_rel = 1'b0;
  logic        slow = 1'b0;
  logic        c_req, p_high, done, rel, req, wr, mem, word, ack, irq, armed;
  logic [19:0] addr;
  logic [15:0] rdata, bwd, brd;
  logic [23:0] log_a [0:63];
  logic [15:0] log_d [0:63];
  int          n_log = 0;
  int          n_irq = 0;
  int          n_rel = 0;
  int          base = 0;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #12.5 sys_clk = ~sys_clk;

  dcp_channel dcp_channel_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .pcb_wr_en(wr_en), .pcb_rd_en(rd_en), .pcb_index(idx), .pcb_wdata(wdata),
    .pcb_rdata(rdata), .external_request_pin(ext_pin), .timer2_request(tmr),
    .channel_is_one(1'b1), .peer_request(p_req), .peer_priority_high(p_hi),
    .peer_transfer_done(1'b0), .peer_bus_released(p_rel), .channel_request(c_req),
    .priority_high(p_high), .transfer_done(done), .bus_released(rel), .bus_req(req),
    .bus_write(wr), .bus_mem_space(mem), .bus_word(word), .bus_addr(addr),
    .bus_wdata(bwd), .bus_ack(ack), .bus_rdata(brd), .tc_irq_request(irq),
    .channel_armed(armed));
  dcp_bus_model dcp_bus_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .bus_req(req), .bus_addr(addr), .bus_ack(ack), .bus_rdata(brd));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    if (req === 1'b1 && ack === 1'b1 && n_log < 64)
    begin
      log_a[n_log] <= {1'b0, wr, mem, word, addr};
      log_d[n_log] <= bwd;
      n_log <= n_log + 1;
    end
    if (irq === 1'b1)
      n_irq <= n_irq + 1;
    if (rel === 1'b1)
      n_rel <= n_rel + 1;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic lg(input int i, input logic [23:0] e);
    chk(log_a[base+i], e, "bus cycle");
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wrr(input logic [2:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    idx   <= i;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rdr(input logic [2:0] i, output logic [15:0] v);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    idx   <= i;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    run(1);
    #1 v = rdata;
  endtask

  // Pointers and count set before the arming control write
  task automatic prog(input logic [19:0] s, input logic [19:0] d, input logic [15:0] n,
                      input logic [15:0] ctl);
    wrr(3'h0, s[15:0]);
    wrr(3'h1, {12'h000, s[19:16]});
    wrr(3'h2, d[15:0]);
    wrr(3'h3, {12'h000, d[19:16]});
    wrr(3'h4, n);
    base = n_log;
    wrr(3'h5, ctl);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] v;
    logic [15:0] tv [5];
    tv = '{16'hA5C3, 16'h0005, 16'h3C96, 16'h000A, 16'h0007};
    for (int i = 0; i < 5; i++)
      wrr(3'(i), tv[i]);
    wrr(3'h6, 16'h1234);
    wrr(3'h5, 16'hFFB3);
    for (int i = 0; i < 5; i++)
    begin
      rdr(3'(i), v);
      chk(24'(v), 24'(tv[i]), "register");
    end
    rdr(3'h6, v);
    chk(24'(v), 24'h000000, "unmapped");
    rdr(3'h5, v);
    chk(24'(v), 24'h00FFB1, "control");
    chk(24'(p_high), 24'h000001, "priority");
    chk(24'(armed), 24'h000000, "armed");
    wrr(3'h5, 16'h0000);
  endtask

  task automatic t_unsync();
    prog(20'h51234, 20'hA0010, 16'h0002, 16'h5407);
    run(40);
    lg(0, 24'h351234);
    lg(1, 24'h5A0010);
    lg(2, 24'h351236);
    lg(3, 24'h5A000E);
    chk(24'(log_d[base+1]), 24'h00486E, "data");
    chk(24'(log_d[base+3]), 24'h00486C, "data");
    chk(24'(n_log - base), 24'h000004, "transfers");
    chk(24'(armed), 24'h000000, "armed");
  endtask

  // Slow bus, byte source in low I/O space
  task automatic t_byte();
    slow <= 1'b1;
    prog(20'h00100, 20'h30200, 16'h0002, 16'hEB46);
    ext_pin <= 1'b1;
    run(60);
    ext_pin <= 1'b0;
    slow <= 1'b0;
    lg(0, 24'h000100);
    lg(1, 24'h630200);
    lg(2, 24'h0000FF);
    lg(3, 24'h630200);
    chk(24'(n_log - base), 24'h000004, "transfers");
    chk(24'(n_irq), 24'h000001, "irq");
    chk(24'(armed), 24'h000000, "armed");
  endtask

  task automatic t_timer();
    prog(20'h00000, 20'h00000, 16'h0001, 16'h0256);
    ext_pin <= 1'b1;
    run(20);
    chk(24'(n_log - base), 24'h000000, "pin ignored");
    tmr <= 1'b1;
    run(1);
    tmr <= 1'b0;
    ext_pin <= 1'b0;
    run(20);
    chk(24'(n_log - base), 24'h000002, "timer");
    chk(24'(n_irq), 24'h000001, "irq");
  endtask

  task automatic t_dst();
    prog(20'h10000, 20'h20000, 16'h0001, 16'h9087);
    ext_pin <= 1'b1;
    run(40);
    ext_pin <= 1'b0;
    run(10);
    chk(24'(n_log - base > 4), 24'h000001, "runs on");
    chk(24'(n_rel > 0), 24'h000001, "released");
    chk(24'(armed), 24'h000001, "armed");
    wrr(3'h5, 16'h9084);
    run(3);
    chk(24'(armed), 24'h000000, "disarmed");
  endtask

  task automatic t_prio();
    p_req <= 1'b1;
    p_hi <= 1'b1;
    prog(20'h00000, 20'h00000, 16'h0001, 16'h0006);
    run(20);
    chk(24'(n_log - base), 24'h000000, "lost");
    chk(24'(c_req), 24'h000001, "req");
    p_hi <= 1'b0;
    p_rel <= 1'b1;
    run(1);
    p_rel <= 1'b0;
    run(20);
    chk(24'(n_log - base), 24'h000002, "rotated");
    p_req <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Tests need about 340 cycles
  initial
  begin
    run(5000);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    run(2);
    rst_n <= 1'b1;
    t_regs();
    t_unsync();
    t_byte();
    t_timer();
    t_dst();
    t_prio();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
